// >>> common/fcc_pkg.sv
// shared constants and types for the flash command control block
package fcc_pkg;
  // control/status register bit positions
  localparam int BIT_IRQ_EN = 7;
  localparam int BIT_DONE = 6;
  localparam int BIT_PE_EN = 5;
  localparam int BIT_READY = 4;
  localparam int BIT_RSV_HI = 3;
  localparam int BIT_PWR_HI = 2;
  localparam int BIT_RSV_LO = 1;
  localparam int BIT_PWR_LO = 0;
  localparam logic [7:0] CSR_RESET = 8'h10;
  localparam logic [7:0] CSR_WMASK = 8'hA5;

  // register port address map (only the full address 0x000000 selects the register)
  localparam logic [23:0] ADDR_CSR = 24'h000000;
  localparam logic [7:0] BANK_HI = 8'hFF;
  localparam logic [7:0] BANK_LO = 8'hFE;
  localparam logic [15:0] OFS_UNLOCK1 = 16'hAAAA;
  localparam logic [15:0] OFS_UNLOCK2 = 16'h5554;

  // command codes in the low byte
  localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_CHIP = 8'h10;
  localparam logic [7:0] CMD_SECTOR = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;

  // timing
  localparam int CLK_MHZ = 100;
  localparam int SECTOR_WAIT_US = 50;
  localparam int SECTOR_WAIT_CYC = SECTOR_WAIT_US * CLK_MHZ;

  typedef enum logic [3:0] {
    SEQ_IDLE = 4'h0,
    SEQ_U1 = 4'h1,
    SEQ_U2 = 4'h2,
    SEQ_PROG = 4'h3,
    SEQ_E3 = 4'h4,
    SEQ_E4 = 4'h5,
    SEQ_E5 = 4'h6
  } fcc_seq_type;

  typedef enum logic [2:0] {
    OP_IDLE = 3'h0,
    OP_PROG = 3'h1,
    OP_CHIP = 3'h2,
    OP_SWAIT = 3'h3,
    OP_SERASE = 3'h4,
    OP_SUSP = 3'h5
  } fcc_op_type;

  // one decoded command write
  typedef struct packed {
    logic valid;
    logic [7:0] bank;
    logic [15:0] ofs;
    logic [7:0] code;
    logic [15:0] word;
  } fcc_cmd_type;

  // request to the flash array
  typedef struct packed {
    logic prog;
    logic chip_erase;
    logic sector_add;
    logic erase_start;
    logic suspend;
    logic resume;
    logic [23:0] addr;
    logic [15:0] word;
  } fcc_strobe_type;
endpackage

// >>> rtl/fcc_cmd_decoder.sv
// command sequence decoder for flash command writes
`timescale 1ns/1ps
module fcc_cmd_decoder
  import fcc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire fcc_cmd_type cmd,
  input wire logic abort,
  output fcc_seq_type seq,
  output logic is_reset,
  output logic got_prog,
  output logic got_chip,
  output logic got_sector,
  output logic got_suspend,
  output logic got_resume
);
  fcc_seq_type seq_reg, seq_next;
  logic on_u1, on_u2, bank_ok;

  assign seq = seq_reg;

  always_comb begin
    // only the offset inside either bank is compared
    bank_ok = (cmd.bank == BANK_HI) || (cmd.bank == BANK_LO);
    on_u1 = bank_ok && (cmd.ofs == OFS_UNLOCK1);
    on_u2 = bank_ok && (cmd.ofs == OFS_UNLOCK2);
    seq_next = seq_reg;
    is_reset = 1'b0;
    got_prog = 1'b0;
    got_chip = 1'b0;
    got_sector = 1'b0;
    got_suspend = 1'b0;
    got_resume = 1'b0;
    if (abort) begin
      seq_next = SEQ_IDLE;
    end else if (cmd.valid && bank_ok) begin
      seq_next = SEQ_IDLE;
      case (seq_reg)
        SEQ_IDLE: begin
          if (cmd.code == CMD_RESET) begin
            is_reset = 1'b1;
          end else if (cmd.code == CMD_SUSPEND) begin
            got_suspend = 1'b1;
          end else if (cmd.code == CMD_SECTOR) begin
            got_resume = 1'b1;
            got_sector = 1'b1;
          end else if (on_u1 && cmd.code == CMD_UNLOCK1) begin
            seq_next = SEQ_U1;
          end
        end
        SEQ_U1: begin
          if (on_u2 && cmd.code == CMD_UNLOCK2) begin
            seq_next = SEQ_U2;
          end
        end
        SEQ_U2: begin
          if (on_u1 && cmd.code == CMD_RESET) begin
            is_reset = 1'b1;
          end else if (on_u1 && cmd.code == CMD_PROGRAM) begin
            seq_next = SEQ_PROG;
          end else if (on_u1 && cmd.code == CMD_ERASE) begin
            seq_next = SEQ_E3;
          end
        end
        SEQ_PROG: begin
          got_prog = 1'b1;
        end
        SEQ_E3: begin
          if (on_u1 && cmd.code == CMD_UNLOCK1) begin
            seq_next = SEQ_E4;
          end
        end
        SEQ_E4: begin
          if (on_u2 && cmd.code == CMD_UNLOCK2) begin
            seq_next = SEQ_E5;
          end
        end
        SEQ_E5: begin
          if (on_u1 && cmd.code == CMD_CHIP) begin
            got_chip = 1'b1;
          end else if (cmd.code == CMD_SECTOR) begin
            got_sector = 1'b1;
          end
        end
        default: seq_next = SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seq_reg <= SEQ_IDLE;
    end else begin
      seq_reg <= seq_next;
    end
  end
endmodule

// >>> rtl/fcc_flash_control.sv
// flash command control: control/status register and operation sequencer
//
// Functional notes
// - completion irq only while irq enable and done flag are both one.
// - done flag sets when program, erase or algorithm finishes.
// - writing zero clears done flag; writing one changes nothing.
// - read-modify-write reads return one in the done flag position.
// - program/erase strobes only when the enable bit is one; the erase start at the end of the sector wait does not check it.
// - ready bit zero while busy, one again once operation completes.
// - reset and suspend commands still accepted while ready is zero, except while a word program runs.
// - two-bit power level field chosen by software per clock rate.
// - done flag and ready bit change in different cycles.
// - commands are word writes; only the low byte is decoded.
// - read mode on F0 write or unlock-unlock-F0 sequence.
// - word program is unlock, unlock, A0, then data word.
// - chip erase is six writes ending with 10 at AAAA.
// - sector erase ends with 30 at an address in the sector.
// - single B0 write suspends an ongoing sector erase.
// - single 30 write resumes a suspended sector erase.
// - either flash bank is accepted; only the offset is compared.
// - all other commands ignored while a word program runs.
// - 50 us wait after each sector code; new codes restart it.
// - suspend ignored in chip erase, programming or when suspended.
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module fcc_flash_control
  import fcc_pkg::*;
#(
  parameter int WAIT_CYC = SECTOR_WAIT_CYC
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [23:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic rmw,
  output logic [15:0] rdata,
  output logic irq,
  output logic [1:0] power_level,
  output fcc_strobe_type strobe,
  input wire logic array_done
);
  // the wait counter is 16 bits wide and must count at least one cycle
  if (WAIT_CYC < 1 || WAIT_CYC > 65535) begin : g_wait_check
    $error("WAIT_CYC out of range");
  end

  logic [7:0] csr_reg, csr_next;
  fcc_op_type op_reg, op_next;
  logic [15:0] wait_reg, wait_next;
  logic ready_set_reg, ready_set_next;
  logic [15:0] rdata_reg, rdata_next;
  logic irq_reg, irq_next;
  logic [1:0] pwr_reg, pwr_next;
  fcc_strobe_type stb_reg, stb_next;

  fcc_cmd_type cmd;
  fcc_seq_type seq;
  logic is_reset, got_prog, got_chip, got_sector;
  logic got_suspend, got_resume, flash_wr, csr_wr, dec_abort;
  logic busy_prog, pe_ok;

  function automatic logic is_flash(input logic [23:0] a);
    is_flash = (a[23:16] == BANK_HI) || (a[23:16] == BANK_LO);
  endfunction

  always_comb begin
    flash_wr = wr && is_flash(addr);
    csr_wr = wr && (addr == ADDR_CSR);
    busy_prog = (op_reg == OP_PROG);
    // starting strobes need the enable bit and the ready bit both set; later sector codes need only enable
    pe_ok = csr_reg[BIT_PE_EN] && csr_reg[BIT_READY];
    cmd.valid = flash_wr && !busy_prog;
    cmd.bank = addr[23:16];
    cmd.ofs = addr[15:0];
    cmd.code = wdata[7:0];
    cmd.word = wdata;
    dec_abort = busy_prog;
  end

  fcc_cmd_decoder u_dec (
    .clk(clk),
    .rst(rst),
    .cmd(cmd),
    .abort(dec_abort),
    .seq(seq),
    .is_reset(is_reset),
    .got_prog(got_prog),
    .got_chip(got_chip),
    .got_sector(got_sector),
    .got_suspend(got_suspend),
    .got_resume(got_resume)
  );

  // operation sequencer
  always_comb begin
    op_next = op_reg;
    wait_next = wait_reg;
    stb_next = '0;
    stb_next.addr = addr;
    stb_next.word = wdata;
    ready_set_next = 1'b0;
    case (op_reg)
      OP_IDLE: begin
        if (got_prog && pe_ok) begin
          stb_next.prog = 1'b1;
          op_next = OP_PROG;
        end else if (got_chip && pe_ok) begin
          stb_next.chip_erase = 1'b1;
          op_next = OP_CHIP;
        end else if (got_sector && seq == SEQ_E5 && pe_ok) begin
          stb_next.sector_add = 1'b1;
          wait_next = 16'(WAIT_CYC);
          op_next = OP_SWAIT;
        end
      end
      OP_PROG, OP_CHIP, OP_SERASE: begin
        if (array_done) begin
          op_next = OP_IDLE;
          ready_set_next = 1'b1;
        end else if (op_reg == OP_SERASE && got_suspend) begin
          stb_next.suspend = 1'b1;
          op_next = OP_SUSP;
        end
      end
      OP_SWAIT: begin
        if (got_suspend) begin
          op_next = OP_SUSP;
          stb_next.suspend = 1'b1;
        end else if (got_sector && csr_reg[BIT_PE_EN]) begin
          stb_next.sector_add = 1'b1;
          wait_next = 16'(WAIT_CYC);
        end else if (wait_reg <= 16'h0001) begin
          stb_next.erase_start = 1'b1;
          op_next = OP_SERASE;
          wait_next = 16'h0000;
        end else begin
          wait_next = wait_reg - 16'h0001;
        end
      end
      OP_SUSP: begin
        // a second suspend is simply ignored here
        if (got_resume) begin
          stb_next.resume = 1'b1;
          // a suspend taken during the wait goes back to waiting
          if (wait_reg != 16'h0000) begin
            op_next = OP_SWAIT;
          end else begin
            op_next = OP_SERASE;
          end
        end
      end
      default: op_next = OP_IDLE;
    endcase
    if (is_reset && !busy_prog) begin
      // reset leaves erase running; it only clears the sequence
      op_next = op_next;
    end
  end

  // control/status register
  always_comb begin
    csr_next = csr_reg;
    if (csr_wr) begin
      csr_next[BIT_IRQ_EN] = wdata[BIT_IRQ_EN];
      csr_next[BIT_PE_EN] = wdata[BIT_PE_EN];
      csr_next[BIT_PWR_HI] = wdata[BIT_PWR_HI];
      csr_next[BIT_PWR_LO] = wdata[BIT_PWR_LO];
      if (!wdata[BIT_DONE]) begin
        csr_next[BIT_DONE] = 1'b0;
      end
    end
    if ((stb_reg.prog || stb_reg.chip_erase || stb_reg.sector_add)) begin
      csr_next[BIT_READY] = 1'b0;
    end
    if (op_reg != OP_IDLE && array_done) begin
      csr_next[BIT_DONE] = 1'b1;
    end
    // ready follows done by one cycle so they never move together
    if (ready_set_reg) begin
      csr_next[BIT_READY] = 1'b1;
    end
    csr_next[BIT_RSV_HI] = 1'b0;
    csr_next[BIT_RSV_LO] = 1'b0;
    irq_next = csr_next[BIT_IRQ_EN] && csr_next[BIT_DONE];
    pwr_next = {csr_next[BIT_PWR_HI], csr_next[BIT_PWR_LO]};
    rdata_next = 16'h0000;
    if (rd && addr == ADDR_CSR) begin
      rdata_next = {8'h00, csr_reg};
      if (rmw) begin
        rdata_next[BIT_DONE] = 1'b1;
      end
    end
  end

  // sequencer state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      op_reg <= OP_IDLE;
      wait_reg <= 16'h0000;
      ready_set_reg <= 1'b0;
      stb_reg <= '0;
    end else begin
      op_reg <= op_next;
      wait_reg <= wait_next;
      ready_set_reg <= ready_set_next;
      stb_reg <= stb_next;
    end
  end

  // register state and registered outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      csr_reg <= CSR_RESET;
      rdata_reg <= 16'h0000;
      irq_reg <= 1'b0;
      pwr_reg <= 2'b00;
    end else begin
      csr_reg <= csr_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
      pwr_reg <= pwr_next;
    end
  end

  assign rdata = rdata_reg;
  assign irq = irq_reg;
  assign power_level = pwr_reg;
  assign strobe = stb_reg;
endmodule

// >>> tb/fcc_array_model.sv
// flash array stand-in: answers each started operation after a delay
`timescale 1ns/1ps
module fcc_array_model
  import fcc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire fcc_strobe_type strobe,
  output logic array_done
);
  int cnt_reg;
  logic hold_reg;
  // a suspended erase freezes its countdown until resumed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 0;
      hold_reg <= 1'b0;
      array_done <= 1'b0;
    end else begin
      array_done <= !hold_reg && cnt_reg == 1;
      if (strobe.prog || strobe.chip_erase || strobe.erase_start)
        cnt_reg <= 40;
      else if (!hold_reg && cnt_reg > 0)
        cnt_reg <= cnt_reg - 1;
      if (strobe.suspend || strobe.resume)
        hold_reg <= strobe.suspend;
    end
  end
endmodule

// >>> tb/fcc_flash_control_asserts.sv
// concurrent checks on the flash command control ports
`timescale 1ns/1ps
module fcc_flash_control_asserts
  import fcc_pkg::*;
#(
  parameter int WAIT_CYC = SECTOR_WAIT_CYC
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [23:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic rmw,
  input wire logic [15:0] rdata,
  input wire logic irq,
  input wire logic [1:0] power_level,
  input wire fcc_strobe_type strobe,
  input wire logic array_done
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_csr_wr;
    wr && addr == ADDR_CSR ##1 !wr;
  endsequence
  sequence s_no_start;
    !strobe.erase_start [*8];
  endsequence
  a_irq_cause: assert property (rd && !rmw && addr == ADDR_CSR |=>
    $past(irq) == (rdata[BIT_IRQ_EN] & rdata[BIT_DONE]))
    else $error("irq mismatch");
  a_rmw_done: assert property (rd && rmw && addr == ADDR_CSR |=>
    rdata[6]) else $error("rmw done bit low");
  a_power_copy: assert property (s_csr_wr |=> power_level ==
    {$past(wdata[2], 2), $past(wdata[0], 2)}) else $error("power");
  a_prog_word: assert property (strobe.prog |-> $past(wr) &&
    strobe.addr == $past(addr) && strobe.word == $past(wdata))
    else $error("program strobe fields");
  a_chip_cause: assert property (strobe.chip_erase |-> $past(wr) &&
    $past(addr[15:0]) == OFS_UNLOCK1 && $past(wdata[7:0]) == CMD_CHIP)
    else $error("chip erase cause");
  a_sector_cause: assert property (strobe.sector_add |->
    $past(wr) && $past(wdata[7:0]) == CMD_SECTOR) else $error("sector");
  a_erase_wait: assert property (strobe.sector_add |=> s_no_start)
    else $error("erase started early");
  a_suspend_once: assert property (strobe.suspend |=>
    !strobe.suspend [*8]) else $error("repeated suspend");
endmodule
bind fcc_flash_control fcc_flash_control_asserts #(.WAIT_CYC(WAIT_CYC)) u_chk (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rmw(rmw), .rdata(rdata), .irq(irq), .power_level(power_level),
  .strobe(strobe), .array_done(array_done)
);

// >>> tb/fcc_flash_control_tb.sv
// self-checking bench for the flash command control block
`timescale 1ns/1ps
module fcc_flash_control_tb;
  import fcc_pkg::*;
  logic clk;
  logic rst;
  logic wr;
  logic rd;
  logic rmw;
  logic irq;
  logic done;
  logic [23:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [1:0] pwr;
  fcc_strobe_type stb;
  logic [7:0] m_csr;
  logic [7:0] v;
  int bad_count = 0;
  int check_count = 0;
  int n_prog = 0, n_chip = 0, n_ers = 0, n_sus = 0, n_res = 0;
  int n_add = 0;
  int e_prog = 0, e_chip = 0;
  fcc_flash_control #(.WAIT_CYC(20)) DUT (.clk(clk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rmw(rmw), .rdata(rdata),
    .irq(irq), .power_level(pwr), .strobe(stb), .array_done(done));
  fcc_array_model u_arr (.clk(clk), .rst(rst), .strobe(stb),
    .array_done(done));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    n_prog += stb.prog;
    n_chip += stb.chip_erase;
    n_ers += stb.erase_start;
    n_sus += stb.suspend;
    n_res += stb.resume;
    n_add += stb.sector_add;
  end
  task automatic chk(string nm, logic [23:0] seen, logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [7:0] rb();
    return 8'($urandom);
  endfunction
  task automatic bw(logic [23:0] a, logic [15:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask
  task automatic idle(int n);
    wr <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task automatic rdc(logic m);
    wr <= 1'b0;
    rd <= 1'b1;
    rmw <= m;
    addr <= ADDR_CSR;
    @(posedge clk);
    rd <= 1'b0;
    rmw <= 1'b0;
    @(negedge clk);
    chk("csr", rdata, {8'h00, m_csr | (m ? 8'h40 : 8'h00)});
    @(posedge clk);
  endtask
  task automatic wcsr(logic [7:0] d);
    bw(ADDR_CSR, {rb(), d});
    idle(1);
    m_csr = (m_csr & ~CSR_WMASK) | (d & CSR_WMASK);
    if (!d[BIT_DONE]) m_csr[BIT_DONE] = 1'b0;
  endtask
  task automatic unl(logic [7:0] b, logic [7:0] c);
    bw({b, OFS_UNLOCK1}, {rb(), CMD_UNLOCK1});
    bw({b, OFS_UNLOCK2}, {rb(), CMD_UNLOCK2});
    bw({b, OFS_UNLOCK1}, {rb(), c});
  endtask
  // the model starts an operation only with enable and ready both set
  task automatic start6(logic [7:0] b, logic [23:0] a, logic [7:0] c);
    if (c == CMD_PROGRAM) begin
      unl(b, c);
      bw(a, {rb(), rb()});
    end else begin
      unl(b, CMD_ERASE);
      unl(b, CMD_CHIP);
    end
    idle(3);
    if (m_csr[BIT_PE_EN] && m_csr[BIT_READY]) begin
      e_prog += (c == CMD_PROGRAM);
      e_chip += (c != CMD_PROGRAM);
      m_csr[BIT_READY] = 1'b0;
    end
  endtask
  task automatic fin();
    int i;
    for (i = 0; i < 200 && done !== 1'b1; i++) @(negedge clk);
    chk("done pulse", done, 1'b1);
    @(posedge clk);
    idle(3);
    m_csr[BIT_DONE] = 1'b1;
    m_csr[BIT_READY] = 1'b1;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #50000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    rmw = 1'b0;
    addr = 24'h000000;
    wdata = 16'h0000;
    m_csr = CSR_RESET;
    void'($urandom(32'h80D479DE));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(1'b0);
    rdc(1'b1);
    v = rb() & 8'h45;
    wcsr(v);
    rdc(1'b0);
    chk("power", pwr, {v[2], v[0]});
    start6(8'hFF, 24'hFF0100, CMD_PROGRAM);
    chk("prog count", n_prog, e_prog);
    $display("test register done");
    wcsr(8'hA0);
    start6(8'hFF, {8'hFF, rb(), rb() & 8'hFE}, CMD_PROGRAM);
    chk("prog count", n_prog, e_prog);
    rdc(1'b0);
    start6(8'hFE, 24'h000000, CMD_CHIP);
    chk("chip count", n_chip, e_chip);
    fin();
    chk("irq", irq, 1'b1);
    rdc(1'b0);
    wcsr(8'h60);
    rdc(1'b0);
    chk("irq", irq, 1'b0);
    wcsr(8'hA0);
    rdc(1'b1);
    $display("test program done");
    start6(8'hFE, 24'h000000, CMD_CHIP);
    chk("chip count", n_chip, e_chip);
    fin();
    wcsr(8'hA0);
    unl(8'hFF, CMD_RESET);
    bw(24'hFF0100, 16'h1234);
    bw({8'hFF, OFS_UNLOCK1}, {rb(), CMD_UNLOCK1});
    bw({8'hFF, OFS_UNLOCK1}, {rb(), CMD_UNLOCK2});
    bw({8'hFF, OFS_UNLOCK1}, {rb(), CMD_PROGRAM});
    bw(24'hFF0100, 16'h1234);
    idle(3);
    chk("prog count", n_prog, e_prog);
    $display("test abort done");
    unl(8'hFF, CMD_ERASE);
    bw({8'hFF, OFS_UNLOCK1}, {rb(), CMD_UNLOCK1});
    bw({8'hFF, OFS_UNLOCK2}, {rb(), CMD_UNLOCK2});
    bw(24'hFF0000, {rb(), CMD_SECTOR});
    idle(5);
    bw(24'hFFC000, {rb(), CMD_SECTOR});
    idle(15);
    chk("erase start", n_ers, 0);
    idle(10);
    chk("erase start", n_ers, 1);
    chk("sector add", n_add, 2);
    bw(24'hFE1236, {rb(), CMD_SUSPEND});
    bw(24'hFF0000, {rb(), CMD_SUSPEND});
    idle(3);
    chk("suspend", n_sus, 1);
    bw(24'hFF2000, {rb(), CMD_SECTOR});
    idle(3);
    chk("resume", n_res, 1);
    fin();
    rdc(1'b0);
    $display("test sector done");
    report_and_stop();
  end
endmodule
